// ==== adc_input_select_scan.v ====
`timescale 1ns/100ps
`default_nettype none
`include "adc_sel_defines.vh"
module adc_input_select_scan #(
  parameter DIV_W = 8
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // register port
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata_q,
  // converter core
  input  wire        sample_done,
  input  wire        seq_start,
  output reg  [4:0]  pos_sel_q,
  output reg         neg_is_pin1_q,
  output reg         charge_time_sel_q,
  output reg         invalid_sel_q,
  output reg         use_setting_b_q,
  output wire        conv_clock_tick,
  // pad and channel enables
  output wire [12:0] pin_digital_mode,
  output wire [12:0] pin_analog_sample,
  output wire [2:0]  internal_ch_enable
);
  // software-visible state
  reg [15:0] input_select_q;
  reg [15:0] pin_config_q;
  reg [15:0] scan_include_q;
  reg        scan_enable_setting_a_q;
  reg        alternate_setting_enable_q;
  reg [DIV_W-1:0] conv_clock_divider_q;

  // scan and alternation state
  reg [4:0]  scan_ch_q;
  reg        scan_started_q;
  reg        b_next_q;

  // decode and datapath
  wire [4:0] next_ch;
  wire       any_scan;
  wire [4:0] pos_a;
  wire [4:0] pos_b;
  wire       neg_a;
  wire       neg_b;
  reg  [4:0] sel_code;
  reg        sel_b;
  wire [1:0] sel_kind;
  wire       bandgap_en;
  wire       half_bg_en;
  wire       core_reg_en;
  reg        wr_input_select;
  reg        wr_pin_config;
  reg        wr_scan_select;
  reg        wr_control;
  reg  [15:0] rd_word;
  wire [15:0] control_word;
  wire [15:0] status_word;

  // code classes; only charge-time and unused classes leave the block
  localparam KIND_PIN      = 2'h0;
  localparam KIND_INTERNAL = 2'h1;
  localparam KIND_CHARGE   = 2'h2;
  localparam KIND_UNUSED   = 2'h3;

  // classify a positive-select code
  function [1:0] code_kind;
    input [4:0] c;
    begin
      if (c <= `CODE_LAST_PIN)
        code_kind = KIND_PIN;
      else if (c <= `CODE_BANDGAP)
        code_kind = KIND_INTERNAL;
      else if (c == `CODE_CHARGE_TIME)
        code_kind = KIND_CHARGE;
      else
        code_kind = KIND_UNUSED;
    end
  endfunction

  assign pos_a = input_select_q[`POS_A_HI:`POS_A_LO];
  assign pos_b = input_select_q[`POS_B_HI:`POS_B_LO];
  assign neg_a = input_select_q[`NEG_A_BIT];
  assign neg_b = input_select_q[`NEG_B_BIT];

  assign pin_digital_mode  = pin_config_q[`PIN_HI:0];
  assign pin_analog_sample = ~pin_config_q[`PIN_HI:0];
  // a set bit switches the internal channel off
  assign bandgap_en  = ~pin_config_q[`CH_BANDGAP];
  assign half_bg_en  = ~pin_config_q[`CH_HALF_BG];
  assign core_reg_en = ~pin_config_q[`CH_CORE_REG];
  // order: band gap, half band gap, regulator
  assign internal_ch_enable = {bandgap_en, half_bg_en, core_reg_en};

  scan_picker #(
    .N (`SCAN_CHANNELS)
  ) u_picker (
    .enables (scan_include_q),
    .current (scan_ch_q),
    .restart (seq_start | ~scan_started_q),
    .next_ch (next_ch),
    .any     (any_scan)
  );

  tad_divider #(
    .W (DIV_W)
  ) u_div (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .div     (conv_clock_divider_q),
    .tick_q  (conv_clock_tick)
  );

  // one-hot write decode, so each register keeps a process of its own
  always @* begin
    wr_input_select = 1'b0;
    wr_pin_config   = 1'b0;
    wr_scan_select  = 1'b0;
    wr_control      = 1'b0;
    if (addr == `ADDR_INPUT_SELECT)
      wr_input_select = wr;
    else if (addr == `ADDR_PIN_CONFIG)
      wr_pin_config = wr;
    else if (addr == `ADDR_SCAN_SELECT)
      wr_scan_select = wr;
    else if (addr == `ADDR_CONTROL)
      wr_control = wr;
  end

  // unimplemented input-select bits are never stored
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      input_select_q <= `RESET_WORD;
    else if (wr_input_select)
      input_select_q <= wdata & `INPUT_SELECT_MASK;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      pin_config_q <= `RESET_WORD;
    else if (wr_pin_config)
      pin_config_q <= wdata;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      scan_include_q <= `RESET_WORD;
    else if (wr_scan_select)
      scan_include_q <= wdata;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scan_enable_setting_a_q    <= 1'b0;
      alternate_setting_enable_q <= 1'b0;
      conv_clock_divider_q       <= {DIV_W{1'b0}};
    end else if (wr_control) begin
      scan_enable_setting_a_q    <= wdata[`CTL_SCAN_BIT];
      alternate_setting_enable_q <= wdata[`CTL_ALT_BIT];
      conv_clock_divider_q       <= wdata[DIV_W-1:0];
    end
  end

  // alternation: a new sequence always starts on setting A
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      b_next_q <= 1'b0;
    else if (seq_start)
      b_next_q <= 1'b0;
    else if (sample_done && alternate_setting_enable_q)
      b_next_q <= ~b_next_q;
    else if (sample_done)
      b_next_q <= 1'b0;
  end

  // scan position; only an A sample advances it
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scan_ch_q      <= 5'h00;
      scan_started_q <= 1'b0;
    end else if (seq_start) begin
      scan_ch_q      <= next_ch;
      scan_started_q <= any_scan;
    end else if (sample_done) begin
      if (!b_next_q && scan_enable_setting_a_q) begin
        scan_ch_q      <= next_ch;
        scan_started_q <= any_scan;
      end
    end else if (!scan_started_q && any_scan) begin
      scan_ch_q      <= next_ch;
      scan_started_q <= 1'b1;
    end else if (!any_scan) begin
      scan_started_q <= 1'b0;
    end
  end

  // selection for the current sample
  always @* begin
    sel_b = alternate_setting_enable_q & b_next_q;
    if (sel_b)
      sel_code = pos_b;
    else if (scan_enable_setting_a_q && scan_started_q)
      sel_code = scan_ch_q;
    else
      sel_code = pos_a;
  end

  assign sel_kind = code_kind(sel_code);

  // selection for the sample now being taken
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      pos_sel_q <= 5'h00;
    else
      pos_sel_q <= sel_code;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      neg_is_pin1_q <= 1'b0;
    else
      neg_is_pin1_q <= sel_b ? neg_b : neg_a;
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      charge_time_sel_q <= 1'b0;
    else
      charge_time_sel_q <= (sel_kind == KIND_CHARGE);
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      invalid_sel_q <= 1'b0;
    else
      invalid_sel_q <= (sel_kind == KIND_UNUSED);
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      use_setting_b_q <= 1'b0;
    else
      use_setting_b_q <= sel_b;
  end

  assign control_word = {scan_enable_setting_a_q,
                         alternate_setting_enable_q,
                         {(`CTL_ALT_BIT-DIV_W){1'b0}},
                         conv_clock_divider_q};
  // status: running, setting B in use, scan channel
  assign status_word  = {8'h00,
                         scan_started_q,
                         use_setting_b_q,
                         1'b0,
                         scan_ch_q};

  // read word decode; holes read zero
  always @* begin
    if (addr == `ADDR_INPUT_SELECT)
      rd_word = input_select_q;
    else if (addr == `ADDR_PIN_CONFIG)
      rd_word = pin_config_q;
    else if (addr == `ADDR_SCAN_SELECT)
      rd_word = scan_include_q;
    else if (addr == `ADDR_CONTROL)
      rd_word = control_word;
    else if (addr == `ADDR_STATUS)
      rd_word = status_word;
    else
      rd_word = `RESET_WORD;
  end

  // read data stand one cycle after the strobe, zero otherwise
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      rdata_q <= `RESET_WORD;
    else if (rd)
      rdata_q <= rd_word;
    else
      rdata_q <= `RESET_WORD;
  end
endmodule // adc_input_select_scan
`default_nettype wire

// ==== adc_sel_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_sel_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata_q,
  // converter side
  input wire logic [4:0]  pos_sel_q,
  input wire logic        charge_time_sel_q,
  input wire logic        invalid_sel_q,
  input wire logic [12:0] pin_digital_mode,
  input wire logic [12:0] pin_analog_sample,
  input wire logic [2:0]  internal_ch_enable
);
  logic [15:0] wd_q;
  // wdata of the previous cycle, taken every cycle, so field slices can be compared a cycle later
  always_ff @(posedge ref_clk) wd_q <= wdata;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  rd_idle_zero_a: assert property (!rd |=> rdata_q == 16'h0000)
    else $error("read data not zero");
  unmapped_zero_a: assert property (
    rd && addr > 4'h4 |=> rdata_q == 16'h0000) else $error("unmapped read");
  sel_gaps_zero_a: assert property (
    rd && addr == 4'h0 |=> (rdata_q & 16'h6060) == 16'h0000)
    else $error("unused bits set");
  pin_mode_a: assert property (
    wr && addr == 4'h1 |=> pin_digital_mode == wd_q[12:0])
    else $error("pin mode wrong");
  analog_inv_a: assert property (
    pin_analog_sample == ~pin_digital_mode) else $error("analog mode wrong");
  int_en_a: assert property (
    wr && addr == 4'h1 |=> internal_ch_enable == ~wd_q[15:13])
    else $error("internal enable wrong");
  code31_a: assert property (
    charge_time_sel_q == (pos_sel_q == 5'h1F)) else $error("code 31 flag");
  unused_code_a: assert property (
    invalid_sel_q == (pos_sel_q[4] && pos_sel_q != 5'h1F))
    else $error("unused code flag");
endmodule // adc_sel_checker
bind adc_input_select_scan adc_sel_checker chk (
  .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata_q(rdata_q), .pos_sel_q(pos_sel_q),
  .charge_time_sel_q(charge_time_sel_q), .invalid_sel_q(invalid_sel_q),
  .pin_digital_mode(pin_digital_mode), .pin_analog_sample(pin_analog_sample),
  .internal_ch_enable(internal_ch_enable));
`default_nettype wire

// ==== adc_sel_defines.vh ====
`ifndef ADC_SEL_DEFINES_VH
`define ADC_SEL_DEFINES_VH
// register addresses
`define ADDR_INPUT_SELECT   4'h0
`define ADDR_PIN_CONFIG     4'h1
`define ADDR_SCAN_SELECT    4'h2
`define ADDR_CONTROL        4'h3
`define ADDR_STATUS         4'h4
// input select layout
`define NEG_B_BIT           15
`define NEG_A_BIT           7
`define POS_B_HI            12
`define POS_B_LO            8
`define POS_A_HI            4
`define POS_A_LO            0
`define INPUT_SELECT_MASK   16'h9F9F
// control register layout
`define CTL_SCAN_BIT        15
`define CTL_ALT_BIT         14
`define CTL_DIV_HI          7
`define CTL_DIV_LO          0
`define CONTROL_MASK        16'hC0FF
// positive select codes
`define CODE_LAST_PIN       5'h0C
`define CODE_CORE_REG       5'h0D
`define CODE_HALF_BG        5'h0E
`define CODE_BANDGAP        5'h0F
`define CODE_CHARGE_TIME    5'h1F
// internal channel bits and register reset word
`define CH_BANDGAP          15
`define CH_HALF_BG          14
`define CH_CORE_REG         13
`define RESET_WORD          16'h0000
// scan channel count and highest pin index
`define PIN_HI              12
`define SCAN_CHANNELS       16
`endif

// ==== scan_picker.v ====
`timescale 1ns/100ps
`default_nettype none
// finds the next enabled channel above the current one, wrapping; on restart, the lowest enabled channel
module scan_picker #(
  parameter N = 16
) (
  // selection
  input  wire [N-1:0] enables,
  input  wire [4:0]   current,
  input  wire         restart,
  // result
  output reg  [4:0]   next_ch,
  output reg          any
);
  integer i;
  reg found;
  always @* begin
    next_ch = 5'h00;
    found   = 1'b0;
    any     = |enables;
    for (i = 0; i < N; i = i + 1) begin
      if (!found && enables[i] && (restart || i > current)) begin
        next_ch = i[4:0];
        found   = 1'b1;
      end
    end
    for (i = 0; i < N; i = i + 1) begin
      if (!found && enables[i]) begin
        next_ch = i[4:0];
        found   = 1'b1;
      end
    end
  end
endmodule // scan_picker
`default_nettype wire

// ==== tad_divider.v ====
`timescale 1ns/100ps
`default_nettype none
// one tick every (div+1) clocks
module tad_divider #(
  parameter W = 8
) (
  // clock and reset
  input  wire         ref_clk,
  input  wire         nrst,
  // control
  input  wire [W-1:0] div,
  // tick
  output reg          tick_q
);
  reg [W-1:0] cnt_q;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= {W{1'b0}};
      tick_q <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q  <= {W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule // tad_divider
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        ref_clk, nrst, wr, rd, sample_done, seq_start;
  logic [3:0]  addr;
  logic [15:0] wdata, d;
  logic [4:0]  p;
  wire  [15:0] rdata_q;
  wire  [4:0]  pos_sel_q;
  wire         neg_is_pin1_q, charge_time_sel_q, invalid_sel_q;
  wire         use_setting_b_q, conv_clock_tick;
  wire  [12:0] pin_digital_mode, pin_analog_sample;
  wire  [2:0]  internal_ch_enable;
  int          error_cnt, n_tests;
  logic [15:0] scan_exp [8] = '{16'h0002, 16'h006F, 16'h0004, 16'h006F,
                                16'h0002, 16'h006F, 16'h0004, 16'h0002};
  adc_input_select_scan uut (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .sample_done(sample_done),
    .seq_start(seq_start), .pos_sel_q(pos_sel_q),
    .neg_is_pin1_q(neg_is_pin1_q), .charge_time_sel_q(charge_time_sel_q),
    .invalid_sel_q(invalid_sel_q), .use_setting_b_q(use_setting_b_q),
    .conv_clock_tick(conv_clock_tick), .pin_digital_mode(pin_digital_mode),
    .pin_analog_sample(pin_analog_sample),
    .internal_ch_enable(internal_ch_enable));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  // outputs follow a pulse two edges later
  task automatic pulse(input logic is_seq);
    @(posedge ref_clk);
    seq_start <= is_seq;
    sample_done <= !is_seq;
    @(posedge ref_clk);
    seq_start <= 1'b0;
    sample_done <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic [15:0] selw();
    return {9'h000, use_setting_b_q, neg_is_pin1_q, pos_sel_q};
  endfunction
  // first pass aligns to a tick, second measures the spacing
  task automatic tick_gap(input int exp);
    int k;
    repeat (2) begin
      k = 0;
      do begin
        @(posedge ref_clk);
        #1 k++;
      end while (conv_clock_tick !== 1'b1 && k < 300);
    end
    chk(k[15:0], exp[15:0]);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    results();
  end
  initial begin
    {nrst, wr, rd, sample_done, seq_start, addr, wdata} = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    chk({3'b000, pin_analog_sample}, 16'h1FFF);
    chk({13'h0000, internal_ch_enable}, 16'h0007);
    for (int a = 0; a < 3; a++) begin
      rreg(a[3:0]);
      chk(d, 16'h0000);
    end
    wreg(4'h0, 16'hFFFF);
    rreg(4'h0);
    chk(d, 16'h9F9F);
    wreg(4'hF, 16'hFFFF);
    rreg(4'hF);
    chk(d, 16'h0000);
    wreg(4'h2, 16'h8001);
    rreg(4'h2);
    chk(d, 16'h8001);
    wreg(4'h1, 16'hA5A5);
    chk({3'b000, pin_digital_mode}, 16'h05A5);
    chk({3'b000, pin_analog_sample}, 16'h1A5A);
    chk({13'h0000, internal_ch_enable}, 16'h0002);
    wreg(4'h3, 16'h0000);
    for (int c = 0; c < 18; c++) begin
      p = (c == 16) ? 5'h1F : (c == 17) ? 5'h13 : c[4:0];
      wreg(4'h0, {8'h00, 3'b100, p});
      pulse(1'b1);
      chk(selw(), {11'h001, p});
      chk({charge_time_sel_q, invalid_sel_q}, {p == 5'h1F, c == 17});
    end
    wreg(4'h0, 16'h8503);
    wreg(4'h3, 16'h4000);
    pulse(1'b1);
    chk(selw(), 16'h0003);
    pulse(1'b0);
    chk(selw(), 16'h0065);
    pulse(1'b0);
    chk(selw(), 16'h0003);
    wreg(4'h2, 16'h0014);
    wreg(4'h0, 16'h8F01);
    wreg(4'h3, 16'hC000);
    for (int i = 0; i < 8; i++) begin
      pulse(i == 0 || i == 7);
      chk(selw(), scan_exp[i]);
    end
    wreg(4'h1, 16'h11C0);
    chk({3'b000, pin_analog_sample}, 16'h0E3F);
    chk({13'h0000, internal_ch_enable}, 16'h0007);
    wreg(4'h2, 16'hA000);
    wreg(4'h3, 16'h8000);
    rreg(4'h3);
    chk(d, 16'h8000);
    for (int i = 0; i < 3; i++) begin
      pulse(i == 0);
      chk(selw(), (i == 1) ? 16'h000F : 16'h000D);
    end
    rreg(4'h4);
    chk(d, 16'h008D);
    wreg(4'h3, 16'h0003);
    rreg(4'h3);
    chk(d, 16'h0003);
    tick_gap(4);
    wreg(4'h3, 16'h0000);
    tick_gap(1);
    results();
  end
endmodule // testbench
`default_nettype wire
